// ### rtl/shs_top.sv
// Purpose: Homing sequencer for one servo axis, APB register slave
// Assumes: Switch, index and torque inputs synchronous to MCLK_I
// Notes:   CE_I low freezes every flip-flop, the APB slave included
//
// The register addresses and the APB register port were left to the implementer.
`default_nettype none
module shs_top
    import shs_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic POS_LIMIT_I,
    input wire logic NEG_LIMIT_I,
    input wire logic HOME_SW_I,
    input wire logic INDEX_I,
    input wire logic [15:0] TORQUE_I,
    output logic MOVE_EN_O,
    output logic MOVE_POS_O,
    output logic [15:0] MOVE_SPEED_O,
    output logic [15:0] MOVE_ACCEL_O
);
    // ============================================================
    // Method table
    function automatic logic in_rng(logic signed [7:0] m, int lo, int hi);
        return (int'(m) >= lo) && (int'(m) <= hi);
    endfunction

    function automatic logic seek_pos(logic signed [7:0] m);
        return m == -8'sd5 || m == -8'sd3 || m == -8'sd1 ||
               in_rng(m, 2, 4) || m == 8'sd34;
    endfunction

    function automatic logic supported(logic signed [7:0] m);
        return in_rng(m, -6, -1) || in_rng(m, 1, 5) || in_rng(m, 33, 34);
    endfunction

    function automatic logic lim_fault(logic signed [7:0] m, logic pl,
                                       logic nl, logic hs);
        logic pg;
        logic ng;
        logic nolim;
        pg = m == 8'sd2 || in_rng(m, 7, 10) || in_rng(m, 23, 26);
        ng = m == 8'sd1 || in_rng(m, 11, 14) || in_rng(m, 27, 30);
        nolim = in_rng(m, 3, 4) || in_rng(m, 19, 20);
        return (pl && nl) ||
               (pg && nl) ||
               (ng && pl) ||
               (nolim && (pl || nl)) ||
               (in_rng(m, 33, 34) && (pl || nl || hs));
    endfunction

    // ============================================================
    // Registers
    shs_cfg_t cfg_ff;
    logic [15:0] cmd_ff;
    logic abs_ff;
    logic start_prev_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    shs_state_t state_ff;
    shs_state_t nxt_state;
    shs_drive_t drive_ff;
    shs_drive_t nxt_drive;
    logic [15:0] speed_ff;
    logic seen_ff;
    logic nxt_seen;
    logic [15:0] dly_cnt_ff;
    logic abn_ff;
    logic reach_ff;
    logic done_ff;
    logic err_ff;
    logic pzero_ff;
    logic trig_ff;
    logic [15:0] stat_word;
    logic wr_en;
    logic start_edge;
    logic stop_edge;
    logic run;
    logic sw;
    logic flt;
    logic trq_hit;
    logic m4;
    logic midx;
    logic sp;
    logic succ;
    logic pzero;
    logic launch;

    assign stat_word = {trig_ff, pzero_ff, err_ff, done_ff, 1'b0,
                        reach_ff, 1'b0, abn_ff, 8'h00};
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_ff;
    assign start_edge = cmd_ff[START_BIT] && !start_prev_ff;
    assign stop_edge = !cmd_ff[START_BIT] && start_prev_ff;
    assign run = state_ff != S_IDLE;
    assign pzero = cfg_ff.method == 8'sd0 || cfg_ff.fast == 16'h0000 ||
                   cfg_ff.slow == 16'h0000 || cfg_ff.accel == 16'h0000;
    assign launch = start_edge && !run && !abs_ff && !pzero &&
                    supported(cfg_ff.method);
    assign sw = cfg_ff.method == 8'sd1 ? NEG_LIMIT_I :
                cfg_ff.method == 8'sd2 ? POS_LIMIT_I : HOME_SW_I;
    assign flt = lim_fault(cfg_ff.method, POS_LIMIT_I, NEG_LIMIT_I,
                           HOME_SW_I);
    assign trq_hit = TORQUE_I >= cfg_ff.thr;
    assign m4 = cfg_ff.method == 8'sd4;
    assign midx = in_rng(cfg_ff.method, 33, 34);
    assign sp = seek_pos(cfg_ff.method);

    // ============================================================
    // APB slave, no wait states
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (CE_I) begin
            pready_ff <= PSEL_I && !PENABLE_I;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            if (PSEL_I && !PENABLE_I) begin
                if (PADDR_I == CMD_OFS) begin
                    prdata_ff <= {16'h0000, cmd_ff};
                end else if (PADDR_I == STAT_OFS) begin
                    prdata_ff <= {16'h0000, stat_word};
                end else if (PADDR_I == METH_OFS) begin
                    prdata_ff <= {24'h000000, cfg_ff.method};
                end else if (PADDR_I == FAST_OFS) begin
                    prdata_ff <= {16'h0000, cfg_ff.fast};
                end else if (PADDR_I == SLOW_OFS) begin
                    prdata_ff <= {16'h0000, cfg_ff.slow};
                end else if (PADDR_I == ACC_OFS) begin
                    prdata_ff <= {16'h0000, cfg_ff.accel};
                end else if (PADDR_I == THR_OFS) begin
                    prdata_ff <= {16'h0000, cfg_ff.thr};
                end else if (PADDR_I == DLY_OFS) begin
                    prdata_ff <= {16'h0000, cfg_ff.dly};
                end else if (PADDR_I == CFG_OFS) begin
                    prdata_ff <= {31'h00000000, abs_ff};
                end else begin
                    pslverr_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            cmd_ff <= CMD_RST;
            cfg_ff <= {METH_RST, PAR_RST, PAR_RST, PAR_RST, PAR_RST,
                       PAR_RST};
            abs_ff <= CFG_RST;
        end else if (CE_I && wr_en) begin
            if (PADDR_I == CMD_OFS) begin
                cmd_ff <= PWDATA_I[15:0];
            end else if (PADDR_I == METH_OFS) begin
                cfg_ff.method <= PWDATA_I[7:0];
            end else if (PADDR_I == FAST_OFS) begin
                cfg_ff.fast <= PWDATA_I[15:0];
            end else if (PADDR_I == SLOW_OFS) begin
                cfg_ff.slow <= PWDATA_I[15:0];
            end else if (PADDR_I == ACC_OFS) begin
                cfg_ff.accel <= PWDATA_I[15:0];
            end else if (PADDR_I == THR_OFS) begin
                cfg_ff.thr <= PWDATA_I[15:0];
            end else if (PADDR_I == DLY_OFS) begin
                cfg_ff.dly <= PWDATA_I[15:0];
            end else if (PADDR_I == CFG_OFS) begin
                abs_ff <= PWDATA_I[ABS_BIT];
            end
        end
    end

    // ============================================================
    // Homing sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_seen = seen_ff;
        succ = 1'b0;
        case (state_ff)
            S_IDLE: begin
                nxt_seen = 1'b0;
                if (launch) begin
                    if (cfg_ff.method < 8'sd0 || midx) begin
                        nxt_state = midx ? S_CREEP : S_SEEK;
                    end else if (sw) begin
                        nxt_state = S_LEAVE;
                    end else begin
                        nxt_state = S_SEEK;
                    end
                end
            end
            S_LEAVE: begin
                if (!sw) begin
                    nxt_state = m4 ? S_CREEP : S_SEEK;
                end
            end
            S_SEEK: begin
                if (cfg_ff.method < 8'sd0) begin
                    if (trq_hit) begin
                        if (cfg_ff.method <= -8'sd5) begin
                            nxt_state = S_IDLE;
                            succ = 1'b1;
                        end else begin
                            nxt_state = S_REV;
                        end
                    end
                end else if (sw) begin
                    nxt_state = m4 ? S_BACK : S_CREEP;
                end
            end
            S_BACK: begin
                if (!sw) begin
                    nxt_state = S_CREEP;
                end
            end
            S_CREEP: begin
                if (!sw) begin
                    nxt_seen = 1'b1;
                end
                if (INDEX_I && (midx || (m4 ? sw : seen_ff))) begin
                    nxt_state = S_IDLE;
                    succ = 1'b1;
                end
            end
            S_REV: begin
                if (!trq_hit) begin
                    nxt_seen = 1'b1;
                    if (cfg_ff.method <= -8'sd3) begin
                        nxt_state = S_DELAY;
                    end
                end
                if (cfg_ff.method >= -8'sd2 && seen_ff && INDEX_I) begin
                    nxt_state = S_IDLE;
                    succ = 1'b1;
                end
            end
            S_DELAY: begin
                if (dly_cnt_ff >= cfg_ff.dly) begin
                    nxt_state = S_IDLE;
                    succ = 1'b1;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (run && (stop_edge || flt)) begin
            nxt_state = S_IDLE;
            succ = 1'b0;
        end
    end

    always_comb begin
        nxt_drive = '0;
        case (nxt_state)
            S_LEAVE, S_BACK: begin
                nxt_drive = '{en: 1'b1, pos: !sp, fast: 1'b1};
            end
            S_SEEK: begin
                nxt_drive = '{en: 1'b1, pos: sp,
                              fast: cfg_ff.method > -8'sd5};
            end
            S_CREEP: begin
                nxt_drive = '{en: 1'b1, pos: (m4 || midx) ? sp : !sp,
                              fast: 1'b0};
            end
            S_REV: begin
                nxt_drive = '{en: 1'b1, pos: !sp, fast: 1'b0};
            end
            default: begin
                nxt_drive = '0;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state_ff <= S_IDLE;
            drive_ff <= '0;
            speed_ff <= 16'h0000;
            seen_ff <= 1'b0;
            start_prev_ff <= 1'b0;
        end else if (CE_I) begin
            state_ff <= nxt_state;
            drive_ff <= nxt_drive;
            speed_ff <= nxt_drive.fast ? cfg_ff.fast : cfg_ff.slow;
            seen_ff <= nxt_seen;
            start_prev_ff <= cmd_ff[START_BIT];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            dly_cnt_ff <= 16'h0000;
        end else if (CE_I) begin
            if (state_ff == S_DELAY) begin
                dly_cnt_ff <= dly_cnt_ff + 16'h0001;
            end else begin
                dly_cnt_ff <= 16'h0000;
            end
        end
    end

    // ============================================================
    // Status flags, cleared only by a start edge except pzero_ff and trig_ff, which follow every cycle
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            abn_ff <= 1'b0;
            reach_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            pzero_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else if (CE_I) begin
            pzero_ff <= pzero;
            trig_ff <= nxt_state != S_IDLE;
            if (start_edge && !run) begin
                abn_ff <= abs_ff || pzero ||
                          !supported(cfg_ff.method);
                err_ff <= abs_ff;
                reach_ff <= 1'b0;
                // Pending done from the last run still lands
                done_ff <= reach_ff && !done_ff;
            end else begin
                if (run && (stop_edge || flt)) begin
                    abn_ff <= 1'b1;
                end
                if (run && flt) begin
                    err_ff <= 1'b1;
                end
                if (succ) begin
                    reach_ff <= 1'b1;
                end
                if (reach_ff) begin
                    done_ff <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // Outputs
    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign MOVE_EN_O = drive_ff.en;
    assign MOVE_POS_O = drive_ff.pos;
    assign MOVE_SPEED_O = speed_ff;
    assign MOVE_ACCEL_O = cfg_ff.accel;

    // ============================================================
    // Checks
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    abort_stops_motor_a: assert property (
        CE_I && run && stop_edge |=> !MOVE_EN_O && abn_ff)
        else $error("abort did not stop the motor");
    fault_abnormal_a: assert property (
        CE_I && run && flt |=> abn_ff && !trig_ff)
        else $error("fault did not flag abnormal stop");
    done_after_reach_a: assert property (
        $rose(done_ff) |-> $past(reach_ff))
        else $error("done rose without position reached");
    param_zero_a: assert property (
        CE_I && cfg_ff.slow == 16'h0000 |=> pzero_ff)
        else $error("zero speed not flagged");
    trigger_shown_a: assert property (
        CE_I && launch |=> trig_ff && MOVE_EN_O)
        else $error("started run not shown as triggered");
    both_limits_a: assert property (
        CE_I && run && POS_LIMIT_I && NEG_LIMIT_I |=> err_ff)
        else $error("both limits not flagged");
    neg_in_pos_a: assert property (
        CE_I && run && cfg_ff.method == 8'sd2 && NEG_LIMIT_I
        |=> err_ff && !MOVE_EN_O)
        else $error("negative limit not flagged");
    pos_in_neg_a: assert property (
        CE_I && run && cfg_ff.method == 8'sd1 && POS_LIMIT_I
        |=> err_ff && state_ff == S_IDLE)
        else $error("positive limit not flagged");
    abs_start_a: assert property (
        CE_I && start_edge && !run && abs_ff
        |=> err_ff && !trig_ff)
        else $error("absolute encoder start not refused");
    flags_hold_a: assert property (
        CE_I && done_ff && !start_edge |=> done_ff)
        else $error("done flag dropped without start");

    run_done_c: cover property (run ##1 done_ff);
    abort_c: cover property (run && stop_edge);
    fault_c: cover property (run && flt);
    delay_c: cover property (state_ff == S_DELAY ##1 reach_ff);
endmodule // shs_top
`default_nettype wire

// ### common/shs_pkg.sv
// Purpose: Shared constants and types of the homing sequencer
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   Offsets are byte addresses
`default_nettype none
package shs_pkg;
    // ============================================================
    // Register offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] METH_OFS = 8'h08;
    localparam logic [7:0] FAST_OFS = 8'h0C;
    localparam logic [7:0] SLOW_OFS = 8'h10;
    localparam logic [7:0] ACC_OFS = 8'h14;
    localparam logic [7:0] THR_OFS = 8'h18;
    localparam logic [7:0] DLY_OFS = 8'h1C;
    localparam logic [7:0] CFG_OFS = 8'h20;
    // ============================================================
    // Field positions
    localparam int START_BIT = 4;
    localparam int ABS_BIT = 0;
    localparam int ST_ABN = 8;
    localparam int ST_REACH = 10;
    localparam int ST_DONE = 12;
    localparam int ST_ERR = 13;
    localparam int ST_PZERO = 14;
    localparam int ST_TRIG = 15;
    // ============================================================
    // Reset values
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [7:0] METH_RST = 8'h00;
    localparam logic [15:0] PAR_RST = 16'h0000;
    localparam logic CFG_RST = 1'b0;
    // ============================================================
    // Types
    typedef struct packed {
        logic signed [7:0] method;
        logic [15:0] fast;
        logic [15:0] slow;
        logic [15:0] accel;
        logic [15:0] thr;
        logic [15:0] dly;
    } shs_cfg_t;
    typedef struct packed {
        logic en;
        logic pos;
        logic fast;
    } shs_drive_t;
    typedef enum logic [2:0] {
        S_IDLE, S_LEAVE, S_SEEK, S_BACK, S_CREEP, S_REV, S_DELAY
    } shs_state_t;
endpackage
`default_nettype wire

// ### verification/shs_axis_model.sv
// Purpose: Axis model with switches, index and torque for the sequencer
// Assumes: One count of travel per clock while the motor moves
// Notes:   Wall enables hard stops at +/-80; inj_i forces switches
`default_nettype none
module shs_axis_model (
    input wire logic clk_i,
    input wire logic load_i,
    input wire logic wall_i,
    input wire logic signed [15:0] start_pos_i,
    input wire logic [2:0] inj_i,
    input wire logic move_en_i,
    input wire logic move_pos_i,
    output logic pos_lim_o,
    output logic neg_lim_o,
    output logic home_o,
    output logic index_o,
    output logic [15:0] torque_o
);
    // ============================================================
    // Position
    int p;
    logic at_wall;
    assign at_wall = wall_i && (p >= 80 || p <= -80);
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            p <= start_pos_i;
        end else if (move_en_i && move_pos_i && !(wall_i && p >= 80)) begin
            p <= p + 1;
        end else if (move_en_i && !move_pos_i && !(wall_i && p <= -80)) begin
            p <= p - 1;
        end
    end
    // ============================================================
    // Sensors
    assign pos_lim_o = (p >= 100) | inj_i[0];
    assign neg_lim_o = (p <= -100) | inj_i[1];
    assign home_o = (p >= 0 && p <= 20) | inj_i[2];
    assign index_o = ((p & 31) == 5);
    assign torque_o = at_wall ? 16'hFFFF : 16'h0000;
endmodule // shs_axis_model
`default_nettype wire

// ### verification/tb_servo_homing_sequencer.sv
// Purpose: Self-checking bench of the homing sequencer
// Assumes: APB master tasks, axis model on the motion side
// Notes:   Each scenario is one task call with its own expectation
`default_nettype none
module tb_servo_homing_sequencer
    import shs_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, er;
    logic plim, nlim, home, idx, men, mpos, load, wall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] torq, spd, acc;
    logic signed [15:0] spos;
    logic [3:0] inj;
    int bad_count, num_checks;
    // ============================================================
    // Instances
    shs_top u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .POS_LIMIT_I(plim), .NEG_LIMIT_I(nlim),
        .HOME_SW_I(home), .INDEX_I(idx), .TORQUE_I(torq),
        .MOVE_EN_O(men), .MOVE_POS_O(mpos), .MOVE_SPEED_O(spd),
        .MOVE_ACCEL_O(acc));
    shs_axis_model u_axis (.clk_i(clk), .load_i(load), .wall_i(wall),
        .start_pos_i(spos), .inj_i(inj[2:0]), .move_en_i(men),
        .move_pos_i(mpos), .pos_lim_o(plim), .neg_lim_o(nlim),
        .home_o(home), .index_o(idx), .torque_o(torq));
    // ============================================================
    // Common tasks
    task report_and_stop;
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task setp(input logic [15:0] sl);
        apb(1'b1, FAST_OFS, 32'h0000_0064);
        apb(1'b1, SLOW_OFS, {16'h0000, sl});
        apb(1'b1, ACC_OFS, 32'h0000_0020);
        apb(1'b1, THR_OFS, 32'h0000_0080);
        apb(1'b1, DLY_OFS, 32'h0000_0005);
    endtask
    // ============================================================
    // Scenarios
    task t_regs;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", (i == 1) ? 32'h0000_4000 : 32'h0, rd);
        end
        apb(1'b1, STAT_OFS, 32'h0000_FFFF);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("status read only", 32'h0000_4000, rd);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask
    task run(input logic signed [7:0] m, input logic signed [15:0] sp,
             input logic [3:0] f, input logic [31:0] ex);
        int n;
        logic [31:0] es;
        logic [31:0] ed;
        wall <= (m < 0);
        spos <= sp;
        load <= 1'b1;
        apb(1'b1, METH_OFS, {24'h0, m});
        load <= 1'b0;
        apb(1'b1, CMD_OFS, 32'h0000_0010);
        repeat (2) @(posedge clk);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("running status", 32'h0000_8000, rd);
        es = (m <= -5 || m >= 33) ? 32'h0000_000A : 32'h0000_0064;
        ed = {31'h0, m == -5 || m == -3 || m == -1 || m == 34 ||
              (m > 1 && m < 5)};
        chk("running accel", 32'h0000_0020, {16'h0, acc});
        chk("first speed", es, {16'h0, spd});
        chk("first direction", ed, {31'h0, mpos});
        inj <= f;
        if (f[3]) apb(1'b1, CMD_OFS, 32'h0);
        n = 0;
        @(negedge clk);
        while (men === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        // Covers the release delay and the done flag after it
        repeat (10) @(posedge clk);
        chk("motor stopped", 32'h0, {31'h0, men});
        apb(1'b0, STAT_OFS, 32'h0);
        chk("final status", ex, rd);
        inj <= 4'h0;
        apb(1'b1, CMD_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("held status", ex, rd);
    endtask
    task refuse(input logic signed [7:0] m, input logic [31:0] cfg,
                input logic [15:0] sl, input logic [31:0] ex);
        setp(sl);
        apb(1'b1, CFG_OFS, cfg);
        apb(1'b1, METH_OFS, {24'h0, m});
        apb(1'b1, CMD_OFS, 32'h0000_0010);
        repeat (3) @(posedge clk);
        chk("no motion", 32'h0, {31'h0, men});
        apb(1'b0, STAT_OFS, 32'h0);
        chk("refused status", ex, rd);
        apb(1'b1, CMD_OFS, 32'h0);
        apb(1'b1, CFG_OFS, 32'h0);
        setp(16'h000A);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst_n, psel, pen, pwr, load, wall} = 6'h02;
        paddr = 8'h00;
        pwdata = 32'h0;
        spos = 16'sh0000;
        inj = 4'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        setp(16'h000A);
        run(8'sd1, 16'sd40, 4'h0, 32'h0000_1400);
        run(8'sd2, -16'sd40, 4'h0, 32'h0000_1400);
        run(8'sd3, -16'sd40, 4'h0, 32'h0000_1400);
        run(8'sd4, -16'sd40, 4'h0, 32'h0000_1400);
        run(8'sd5, 16'sd60, 4'h0, 32'h0000_1400);
        run(-8'sd6, 16'sd40, 4'h0, 32'h0000_1400);
        run(-8'sd5, 16'sd40, 4'h0, 32'h0000_1400);
        run(-8'sd4, 16'sd40, 4'h0, 32'h0000_1400);
        run(-8'sd3, 16'sd40, 4'h0, 32'h0000_1400);
        run(-8'sd2, 16'sd40, 4'h0, 32'h0000_1400);
        run(-8'sd1, 16'sd40, 4'h0, 32'h0000_1400);
        run(8'sd33, 16'sd60, 4'h0, 32'h0000_1400);
        run(8'sd34, 16'sd60, 4'h0, 32'h0000_1400);
        run(8'sd1, 16'sd40, 4'h1, 32'h0000_2100);
        run(8'sd2, -16'sd40, 4'h2, 32'h0000_2100);
        run(8'sd3, -16'sd40, 4'h1, 32'h0000_2100);
        run(8'sd4, -16'sd40, 4'h2, 32'h0000_2100);
        run(8'sd33, 16'sd60, 4'h4, 32'h0000_2100);
        run(-8'sd6, 16'sd40, 4'h3, 32'h0000_2100);
        run(8'sd1, 16'sd40, 4'h8, 32'h0000_0100);
        refuse(8'sd1, 32'h1, 16'h000A, 32'h0000_2100);
        refuse(8'sd36, 32'h0, 16'h000A, 32'h0000_0100);
        refuse(8'sd1, 32'h0, 16'h0000, 32'h0000_4100);
        report_and_stop();
    end
endmodule // tb_servo_homing_sequencer
`default_nettype wire
